//--- mag_i2c_pkg.sv
// package: constants and carrier types for the magnetometer i2c slave
package mag_i2c_pkg;
  // =====================================================================
  // link framing
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam int unsigned CLOCKS_PER_BYTE = 9;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // address pattern 0110xx0, xx strapped
  localparam logic [1:0] ADDR_HI_BITS = 2'h1;
  localparam logic [3:0] ADDR_FIXED_HI = 4'h6;
  localparam logic DIR_READ = 1'b1;
  // =====================================================================
  // register space
  localparam logic [7:0] PTR_COMMAND = 8'h00;
  localparam logic [7:0] PTR_X_HIGH = 8'h01;
  localparam logic [7:0] PTR_X_LOW = 8'h02;
  localparam logic [7:0] PTR_Y_HIGH = 8'h03;
  localparam logic [7:0] PTR_Y_LOW = 8'h04;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam int unsigned CMD_MEASURE_POS = 0;
  localparam int unsigned CMD_FWD_STRAP_POS = 1;
  localparam int unsigned CMD_REV_STRAP_POS = 2;
  localparam logic [7:0] CMD_WRITABLE_MASK = 8'h07;
  localparam int unsigned AXIS_SIG_BITS = 12;
  // =====================================================================
  // fifo
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_WIDTH = 8;
  // one axis sample: 12 significant bits
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
  } axis_sample_t;
  // one byte written by the master
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } wr_byte_t;
endpackage

//--- byte_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = wr_valid_in && wr_ready_out;
  wire pop = rd_valid_out && rd_ready_in;
  // honest flags from the occupancy count
  assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_reg != '0);
  assign rd_data_out = mem[rd_ptr_reg];
  // storage has no reset, only pointers and count do
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data_in;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // empty or full count must coincide with the pointers meeting
  property p_count_ptrs_agree;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (count_reg == '0 || count_reg == (AW+1)'(DEPTH)) |-> (wr_ptr_reg == rd_ptr_reg);
  endproperty
  a_count_ptrs_agree: assert property (p_count_ptrs_agree) else $error("fifo count off");
endmodule

//--- mag_i2c_slave.sv
// magnetometer i2c slave: link engine, command register, read stream
`timescale 1ns/1ps
// =====================================================================
// Behaviour
// - data changes only while clock low
// - falling data, clock high: start
// - rising data, clock high: stop
// - eight bits plus acknowledge per byte
// - bytes shifted most significant bit first
// - answer address 0110xx0, xx strapped
// - eighth address bit: one read
// - acknowledge own address on ninth clock
// - slave only, never starts transfers
// - measure request also wakes device
// - measure done clears bit zero
// - bit one fires forward strap pulse
// - bit two fires reverse strap pulse
// - after master ack drive next byte
// - up to five bytes from pointer zero
// - order command, x high/low, y high/low
// - axes twelve bits, upper bits zero
// - pointer advances after each read byte
// - reset clears command and pointer
// - both strap bits: forward only
module mag_i2c_slave (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] addr_strap_in,
  input wire logic measurement_done_signal_in,
  input wire logic strap_pulse_done_signal_in,
  input wire mag_i2c_pkg::axis_sample_t sample_in,
  output logic wake_out,
  output logic measure_start_out,
  output logic fwd_strap_start_out,
  output logic rev_strap_start_out,
  output logic [7:0] command_out,
  output logic [7:0] pointer_out
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_IGNORE} link_state_t;
  // =====================================================================
  // line edge detection
  logic scl_prev_reg;
  logic sda_prev_reg;
  wire scl_rise = scl_in && !scl_prev_reg;
  wire scl_fall = !scl_in && scl_prev_reg;
  wire start_seen = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
  wire stop_seen = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end
  // =====================================================================
  // bit engine state
  link_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic ack_drive_reg;
  logic tx_drive_reg;
  logic first_wr_reg;
  logic [7:0] pointer_reg;
  logic [7:0] command_reg;
  // ninth clock is the acknowledge slot
  wire ack_slot = (bit_cnt_reg == mag_i2c_pkg::ACK_SLOT);
  wire byte_done = scl_rise && (bit_cnt_reg == 4'(mag_i2c_pkg::BITS_PER_BYTE - 1));
  wire [7:0] rx_byte = {shift_reg[6:0], sda_in};
  wire addr_match = (rx_byte[7:4] == mag_i2c_pkg::ADDR_FIXED_HI)
                    && (rx_byte[3:2] == addr_strap_in) && !rx_byte[1];
  wire dir_read = (rx_byte[0] == mag_i2c_pkg::DIR_READ);
  // the ack slot right after a read address is ours, not the master's; counting it
  // would step the pointer before the first byte went out
  wire master_slot = scl_rise && ack_slot && (state_reg == ST_READ) && !first_wr_reg;
  wire master_ack = master_slot && !sda_in;
  wire master_nack = master_slot && sda_in;
  // =====================================================================
  // read byte selection
  wire [15:0] x_word = {{(16 - mag_i2c_pkg::AXIS_SIG_BITS){1'b0}}, sample_in.x};
  wire [15:0] y_word = {{(16 - mag_i2c_pkg::AXIS_SIG_BITS){1'b0}}, sample_in.y};
  logic [7:0] read_sel;
  // fixed read order, zero fill, live readback
  always_comb begin
    unique case (pointer_reg)
      mag_i2c_pkg::PTR_COMMAND: read_sel = command_reg;
      mag_i2c_pkg::PTR_X_HIGH: read_sel = x_word[15:8];
      mag_i2c_pkg::PTR_X_LOW: read_sel = x_word[7:0];
      mag_i2c_pkg::PTR_Y_HIGH: read_sel = y_word[15:8];
      mag_i2c_pkg::PTR_Y_LOW: read_sel = y_word[7:0];
      default: read_sel = 8'h00;
    endcase
  end
  // =====================================================================
  // write path through the fifo; the command logic drains it
  mag_i2c_pkg::wr_byte_t wr_byte;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic [8:0] fifo_rd_data;
  mag_i2c_pkg::wr_byte_t fifo_head;
  wire wr_push = byte_done && (state_reg == ST_WRITE) && fifo_wr_ready;
  assign wr_byte = '{first: first_wr_reg, data: rx_byte};
  assign fifo_head = mag_i2c_pkg::wr_byte_t'(fifo_rd_data);
  byte_fifo #(
    .WIDTH(9),
    .DEPTH(mag_i2c_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(wr_byte),
    // a byte that meets a full fifo is dropped and left unacknowledged
    .wr_valid_in(wr_push),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(fifo_rd_data),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(1'b1)
  );
  wire pop_ptr = fifo_rd_valid && fifo_head.first;
  wire pop_cmd = fifo_rd_valid && !fifo_head.first;
  // =====================================================================
  // link state machine; reacts to start, stop and the master's rising clocks
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      first_wr_reg <= 1'b0;
    end else if (start_seen) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
    end else if (stop_seen) begin
      state_reg <= ST_IDLE;
    end else if (scl_rise && state_reg != ST_IDLE) begin
      shift_reg <= rx_byte;
      bit_cnt_reg <= ack_slot ? 4'h0 : bit_cnt_reg + 4'h1;
      if (byte_done && state_reg == ST_ADDR) begin
        state_reg <= !addr_match ? ST_IGNORE : (dir_read ? ST_READ : ST_WRITE);
        first_wr_reg <= 1'b1;
      end else if (byte_done && state_reg == ST_WRITE) begin
        first_wr_reg <= 1'b0;
      end
      if (ack_slot && state_reg == ST_READ) first_wr_reg <= 1'b0;
      if (master_nack) state_reg <= ST_IGNORE;
    end
  end
  // =====================================================================
  // sda drive: acknowledge and read data change only on scl low
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_drive_reg <= 1'b0;
      tx_drive_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else if (start_seen || stop_seen) begin
      ack_drive_reg <= 1'b0;
      tx_drive_reg <= 1'b0;
    end else if (scl_fall) begin
      // ack own address; write bytes acked while fifo has room
      ack_drive_reg <= ack_slot && ((state_reg == ST_READ && first_wr_reg)
        || (state_reg == ST_WRITE && fifo_wr_ready));
      // load and shift only on the falling clock
      if (state_reg == ST_READ && bit_cnt_reg == 4'h0 && tx_drive_reg == 1'b0) begin
        tx_reg <= {read_sel[6:0], 1'b0};
        tx_drive_reg <= !read_sel[7];
      end else if (state_reg == ST_READ && bit_cnt_reg < 4'h8 && bit_cnt_reg != 4'h0) begin
        tx_drive_reg <= !tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end else begin
        tx_drive_reg <= 1'b0;
      end
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_out = ack_drive_reg || tx_drive_reg;
  // =====================================================================
  // pointer and command register
  logic [7:0] pointer_next;
  logic [7:0] command_next;
  wire [7:0] wr_cmd = fifo_head.data & mag_i2c_pkg::CMD_WRITABLE_MASK;
  // auto increment; five bytes wrap to command
  assign pointer_next = pop_ptr ? fifo_head.data :
    (master_ack || master_nack) ?
      ((pointer_reg == mag_i2c_pkg::PTR_Y_LOW) ? mag_i2c_pkg::PTR_COMMAND
       : pointer_reg + 8'h01) : pointer_reg;
  // done signals clear, a new write in the same cycle wins
  always_comb begin
    command_next = command_reg;
    if (measurement_done_signal_in) command_next[mag_i2c_pkg::CMD_MEASURE_POS] = 1'b0;
    if (strap_pulse_done_signal_in) begin
      command_next[mag_i2c_pkg::CMD_FWD_STRAP_POS] = 1'b0;
      command_next[mag_i2c_pkg::CMD_REV_STRAP_POS] = 1'b0;
    end
    if (pop_cmd) begin
      command_next = wr_cmd;
      // forward only when both strap bits set
      if (wr_cmd[mag_i2c_pkg::CMD_FWD_STRAP_POS]) begin
        command_next[mag_i2c_pkg::CMD_REV_STRAP_POS] = 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pointer_reg <= mag_i2c_pkg::PTR_RESET;
      command_reg <= mag_i2c_pkg::COMMAND_RESET;
    end else begin
      pointer_reg <= pointer_next;
      command_reg <= command_next;
    end
  end
  // =====================================================================
  // start pulses to the analog side
  logic measure_start_reg;
  logic fwd_start_reg;
  logic rev_start_reg;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      measure_start_reg <= 1'b0;
      fwd_start_reg <= 1'b0;
      rev_start_reg <= 1'b0;
    end else begin
      measure_start_reg <= pop_cmd && wr_cmd[mag_i2c_pkg::CMD_MEASURE_POS];
      fwd_start_reg <= pop_cmd && wr_cmd[mag_i2c_pkg::CMD_FWD_STRAP_POS];
      rev_start_reg <= pop_cmd && wr_cmd[mag_i2c_pkg::CMD_REV_STRAP_POS]
                       && !wr_cmd[mag_i2c_pkg::CMD_FWD_STRAP_POS];
    end
  end
  assign measure_start_out = measure_start_reg;
  assign fwd_strap_start_out = fwd_start_reg;
  assign rev_strap_start_out = rev_start_reg;
  // wake held while any command is pending
  assign wake_out = |command_reg;
  assign command_out = command_reg;
  assign pointer_out = pointer_reg;
  // =====================================================================
  // checks
  property p_ack_in_slot;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (ack_drive_reg && scl_rise) |-> ack_slot;
  endproperty
  a_ack_in_slot: assert property (p_ack_in_slot) else $error("ack outside ninth clock");
  property p_drive_change_scl_low;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (scl_in && scl_prev_reg && !start_seen && !stop_seen) |=> $stable(sda_oe_out);
  endproperty
  a_drive_change_scl_low: assert property (p_drive_change_scl_low) else $error("sda moved");
  property p_start_enters_addr;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      start_seen |=> (state_reg == ST_ADDR) && (bit_cnt_reg == 4'h0);
  endproperty
  a_start_enters_addr: assert property (p_start_enters_addr) else $error("start missed");
  property p_stop_idles;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      stop_seen |=> (state_reg == ST_IDLE) && !sda_oe_out;
  endproperty
  a_stop_idles: assert property (p_stop_idles) else $error("stop missed");
  property p_bitcnt_range;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      bit_cnt_reg <= 4'(mag_i2c_pkg::CLOCKS_PER_BYTE - 1);
  endproperty
  a_bitcnt_range: assert property (p_bitcnt_range) else $error("bit count overrun");
  property p_foreign_addr_ignored;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (byte_done && state_reg == ST_ADDR && !addr_match) |=> state_reg == ST_IGNORE;
  endproperty
  a_foreign_addr_ignored: assert property (p_foreign_addr_ignored) else $error("bad addr");
  property p_dir_read;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (byte_done && state_reg == ST_ADDR && addr_match && dir_read && !start_seen
       && !stop_seen) |=> state_reg == ST_READ;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction wrong");
  property p_measure_clears;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (measurement_done_signal_in && !pop_cmd) |=> !command_reg[0];
  endproperty
  a_measure_clears: assert property (p_measure_clears) else $error("measure not cleared");
  property p_strap_clears;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (strap_pulse_done_signal_in && !pop_cmd) |=> command_reg[2:1] == 2'b00;
  endproperty
  a_strap_clears: assert property (p_strap_clears) else $error("strap not cleared");
  property p_forward_only;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      fwd_strap_start_out |-> !rev_strap_start_out;
  endproperty
  a_forward_only: assert property (p_forward_only) else $error("both straps fired");
  property p_pointer_wraps;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      pointer_reg <= mag_i2c_pkg::PTR_Y_LOW || pop_ptr || $past(pop_ptr);
  endproperty
  a_pointer_wraps: assert property (p_pointer_wraps) else $error("pointer past y low");
  property p_pointer_step;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (master_ack && !pop_ptr && pointer_reg < mag_i2c_pkg::PTR_Y_LOW)
        |=> pointer_reg == $past(pointer_reg) + 8'h01;
  endproperty
  a_pointer_step: assert property (p_pointer_step) else $error("pointer stuck");
  // read data must be released before the master's slot, or its nack is lost
  property p_master_slot_free;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      master_slot |-> !sda_oe_out;
  endproperty
  a_master_slot_free: assert property (p_master_slot_free) else $error("slave held slot");
  // high bytes of both axes carry four zero bits
  property p_axis_zero_fill;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (pointer_reg == mag_i2c_pkg::PTR_X_HIGH || pointer_reg == mag_i2c_pkg::PTR_Y_HIGH)
        |-> read_sel[7:4] == 4'h0;
  endproperty
  a_axis_zero_fill: assert property (p_axis_zero_fill) else $error("axis not zero filled");
  property p_measure_wakes;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      measure_start_out |-> wake_out;
  endproperty
  a_measure_wakes: assert property (p_measure_wakes) else $error("measure without wake");
  c_nack: cover property (@(posedge sys_clk_in) master_nack);
  c_read_ack: cover property (@(posedge sys_clk_in) master_ack);
  c_measure: cover property (@(posedge sys_clk_in) measure_start_out);
  c_fwd: cover property (@(posedge sys_clk_in) fwd_strap_start_out);
  c_rev: cover property (@(posedge sys_clk_in) rev_strap_start_out);
endmodule

//--- i2c_master_model.sv
// bus master model: drives the link clock and pulls the data line
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HALF = 6
) (
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // =====================================================================
  // idle bus: both lines released, pull-ups hold them high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // one half period of the link clock, kept well above the 4-cycle minimum
  task automatic half_wait();
    repeat (HALF) @(posedge sys_clk_in);
  endtask

  task automatic start_cond();
    half_wait();
    sda_out <= 1'b0;
    half_wait();
    scl_out <= 1'b0;
    half_wait();
  endtask

  task automatic stop_cond();
    sda_out <= 1'b0;
    half_wait();
    scl_out <= 1'b1;
    half_wait();
    sda_out <= 1'b1;
    half_wait();
  endtask

  // data set only while clock low
  task automatic put_bit(input logic b, output logic got);
    sda_out <= b;
    half_wait();
    scl_out <= 1'b1;
    half_wait();
    got = sda_in; // sampled late in the high phase, slave has settled
    scl_out <= 1'b0;
    half_wait();
  endtask

  // eight bits msb first, then the slave's acknowledge
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], g);
    end
    put_bit(1'b1, ack);
  endtask

  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(nack, g);
  endtask
endmodule

//--- tb_mag_i2c_slave.sv
// testbench for the magnetometer i2c slave
`timescale 1ns/1ps
module tb_mag_i2c_slave;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] cmd;
    logic [2:0] pulses;
  } row_t;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic scl_m, sda_m, sda_out, sda_oe_out, wake_out, m_out, f_out, r_out;
  logic [1:0] strap = 2'h2;
  logic meas_done = 1'b0;
  logic strap_done = 1'b0;
  mag_i2c_pkg::axis_sample_t sample = '0;
  logic [7:0] command_out, pointer_out;
  // open drain: the line is low if either party pulls it
  wire sda_bus = sda_m & (sda_oe_out ? sda_out : 1'b1);
  int failures = 0;
  int cmp_count = 0;
  int n_m = 0, n_f = 0, n_r = 0;
  // written byte, command read back, pulses {measure, forward, reverse}
  row_t rows [5] = '{'{8'h01, 8'h01, 3'b100}, '{8'h02, 8'h02, 3'b010},
    // both strap bits written: only the forward bit stays set
    '{8'h04, 8'h04, 3'b001}, '{8'h06, 8'h02, 3'b010}, '{8'hFF, 8'h03, 3'b110}};

  always #4 sys_clk_in = ~sys_clk_in;

  mag_i2c_slave uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_m),
    .sda_in(sda_bus), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_strap_in(strap),
    .measurement_done_signal_in(meas_done), .strap_pulse_done_signal_in(strap_done),
    .sample_in(sample), .wake_out(wake_out), .measure_start_out(m_out),
    .fwd_strap_start_out(f_out), .rev_strap_start_out(r_out), .command_out(command_out),
    .pointer_out(pointer_out));

  i2c_master_model master (.sys_clk_in(sys_clk_in), .sda_in(sda_bus), .scl_out(scl_m),
    .sda_out(sda_m));

  // =====================================================================
  // helpers
  // start pulses are one cycle wide, so count them rather than poll
  always @(posedge sys_clk_in) begin
    if (m_out === 1'b1) n_m <= n_m + 1;
    if (f_out === 1'b1) n_f <= n_f + 1;
    if (r_out === 1'b1) n_r <= n_r + 1;
  end

  task automatic waits(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // address, pointer zero, optional command byte, stop
  task automatic do_write(input logic [7:0] addr, input logic ack_exp, input logic with_data,
    input logic [7:0] data);
    logic a;
    master.start_cond();
    master.write_byte(addr, a);
    check({7'h00, a}, {7'h00, ~ack_exp}, "address ack");
    if (ack_exp) begin
      master.write_byte(8'h00, a);
      check({7'h00, a}, 8'h00, "pointer ack");
      if (with_data) begin
        master.write_byte(data, a);
        check({7'h00, a}, 8'h00, "data ack");
      end
    end
    master.stop_cond();
    waits(20);
  endtask

  task automatic done_pulse(input logic m, input logic s);
    meas_done <= m;
    strap_done <= s;
    @(posedge sys_clk_in);
    meas_done <= 1'b0;
    strap_done <= 1'b0;
    waits(6);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    logic [7:0] got;
    logic a;
    logic [7:0] exp [5];
    int b0, b1, b2;
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    waits(4);
    check(command_out, 8'h00, "reset command");
    check(pointer_out, 8'h00, "reset pointer");
    check({7'h00, sda_oe_out}, 8'h00, "idle drive");
    $display("test reset done");
    foreach (rows[i]) begin
      b0 = n_m;
      b1 = n_f;
      b2 = n_r;
      do_write({4'h6, strap, 2'b00}, 1'b1, 1'b1, rows[i].data);
      check(command_out, rows[i].cmd, "command value");
      check({5'h00, n_m == b0 + 1, n_f == b1 + 1, n_r == b2 + 1}, {5'h00, rows[i].pulses},
        "start pulses");
      check({7'h00, wake_out}, {7'h00, rows[i].cmd != 8'h00}, "wake");
      done_pulse(1'b1, 1'b1);
      check(command_out, 8'h00, "both cleared");
    end
    $display("test command rows done");
    // a foreign strap and a foreign fixed part must both be ignored
    for (int k = 0; k < 2; k++) begin
      do_write(k == 0 ? {4'h6, ~strap, 2'b00} : {4'hE, strap, 2'b00}, 1'b0, 1'b1, 8'h01);
      check(command_out, 8'h00, "foreign write");
    end
    $display("test foreign address done");
    do_write({4'h6, strap, 2'b00}, 1'b1, 1'b1, 8'h03);
    done_pulse(1'b1, 1'b0);
    check(command_out, 8'h02, "measure cleared");
    check({7'h00, wake_out}, 8'h01, "still awake");
    done_pulse(1'b0, 1'b1);
    check(command_out, 8'h00, "strap cleared");
    check({7'h00, wake_out}, 8'h00, "asleep");
    $display("test separate clears done");
    sample <= {12'hA5C, 12'h3F1};
    do_write({4'h6, strap, 2'b00}, 1'b1, 1'b1, 8'h01);
    do_write({4'h6, strap, 2'b00}, 1'b1, 1'b0, 8'h00);
    exp = '{8'h01, 8'h0A, 8'h5C, 8'h03, 8'hF1};
    master.start_cond();
    master.write_byte({4'h6, strap, 2'b01}, a);
    check({7'h00, a}, 8'h00, "read address ack");
    for (int i = 0; i < 5; i++) begin
      master.read_byte(i == 4, got);
      check(got, exp[i], "read byte");
    end
    master.stop_cond();
    waits(20);
    check(pointer_out, 8'h00, "pointer wrap");
    $display("test five byte read done");
    // reset again while a measurement is still pending
    rst_n_in <= 1'b0;
    waits(2);
    rst_n_in <= 1'b1;
    waits(4);
    check(command_out, 8'h00, "mid run reset");
    check({7'h00, wake_out}, 8'h00, "reset wake");
    $display("test mid run reset done");
    end_sim();
  end

  // the whole run needs about 5700 cycles
  initial begin
    waits(30000);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
